/* core/hap_i2c_slave.sv */
`default_nettype none
module hap_i2c_slave (
   input wire logic clk, // System clock
   input wire logic rstn, // Async reset, active low
   input wire logic scl_i, // Serial clock level
   input wire logic sda_i, // Serial data level
   input wire logic [7:0] rd_data, // Register value at ptr
   output logic sda_oe, // Pull data line low
   output logic [7:0] ptr, // Register pointer
   output hap_pkg::hap_acc_t acc // Write strobe, address, data
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DEV = 3'b001,
      ST_REG = 3'b010,
      ST_WR = 3'b011,
      ST_RD = 3'b100
   } hap_i2c_st_t;
   hap_i2c_st_t st_ff;
   logic scl_p_ff, sda_p_ff, oe_ff, nack_ff;
   logic [3:0] cnt_ff;
   logic [7:0] sh_ff, tx_ff, ptr_ff;
   hap_pkg::hap_acc_t acc_ff;
   wire scl_rise = scl_i & ~scl_p_ff;
   wire scl_fall = ~scl_i & scl_p_ff;
   wire start = scl_i & scl_p_ff & sda_p_ff & ~sda_i;
   wire stop = scl_i & scl_p_ff & ~sda_p_ff & sda_i;
   assign sda_oe = oe_ff;
   assign ptr = ptr_ff;
   assign acc = acc_ff;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= ST_IDLE;
         scl_p_ff <= 1'b1;
         sda_p_ff <= 1'b1;
         oe_ff <= 1'b0;
         nack_ff <= 1'b0;
         cnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         tx_ff <= 8'h00;
         ptr_ff <= 8'h00;
         acc_ff <= '0;
      end else begin
         acc_ff.wr <= 1'b0;
         scl_p_ff <= scl_i;
         sda_p_ff <= sda_i;
         if (start) begin
            st_ff <= ST_DEV;
            // Start's own clock fall wraps the count to zero
            cnt_ff <= 4'hf;
            oe_ff <= 1'b0;
         end else if (stop) begin
            st_ff <= ST_IDLE;
            oe_ff <= 1'b0;
         end else if (st_ff != ST_IDLE && scl_rise) begin
            if (cnt_ff != 4'h8) sh_ff <= {sh_ff[6:0], sda_i};
            else if (st_ff == ST_RD) nack_ff <= sda_i;
         end else if (st_ff != ST_IDLE && scl_fall) begin
            if (cnt_ff == 4'h8) begin
               cnt_ff <= 4'h0;
               oe_ff <= 1'b0;
               if (st_ff == ST_RD && nack_ff) st_ff <= ST_IDLE;
               else if (st_ff == ST_RD) begin
                  tx_ff <= {rd_data[6:0], 1'b0};
                  oe_ff <= ~rd_data[7];
               end
            end else begin
               cnt_ff <= cnt_ff + 4'h1;
               if (cnt_ff == 4'h7) begin
                  unique case (st_ff)
                     ST_DEV: begin
                        oe_ff <= (sh_ff[7:1] == hap_pkg::DEV_ADDR);
                        nack_ff <= 1'b0;
                        if (sh_ff[7:1] != hap_pkg::DEV_ADDR) st_ff <= ST_IDLE;
                        else st_ff <= sh_ff[0] ? ST_RD : ST_REG;
                     end
                     ST_REG: begin
                        oe_ff <= 1'b1;
                        ptr_ff <= sh_ff;
                        st_ff <= ST_WR;
                     end
                     ST_WR: begin
                        oe_ff <= 1'b1;
                        acc_ff <= '{wr: 1'b1, addr: ptr_ff, data: sh_ff};
                        ptr_ff <= ptr_ff + 8'h01;
                     end
                     ST_RD: begin
                        oe_ff <= 1'b0;
                        ptr_ff <= ptr_ff + 8'h01;
                     end
                     default: st_ff <= ST_IDLE;
                  endcase
               end else if (st_ff == ST_RD) begin
                  oe_ff <= ~tx_ff[7];
                  tx_ff <= {tx_ff[6:0], 1'b0};
               end
            end
         end
      end
   end
endmodule // hap_i2c_slave
`default_nettype wire

/* core/hap_pkg.sv */
`default_nettype none
package hap_pkg;
   // ==========================================
   // Register offsets
   localparam logic [7:0] OFF_FSTAT = 8'h00;
   localparam logic [7:0] OFF_SSTAT = 8'h01;
   localparam logic [7:0] OFF_CSTAT = 8'h02;
   localparam logic [7:0] OFF_FINT = 8'h03;
   localparam logic [7:0] OFF_EINT = 8'h04;
   localparam logic [7:0] OFF_CINT = 8'h05;
   localparam logic [7:0] OFF_FMSK = 8'h06;
   localparam logic [7:0] OFF_EMSK = 8'h07;
   localparam logic [7:0] OFF_CMSK = 8'h08;
   localparam logic [7:0] OFF_CTRL = 8'h09;
   localparam logic [7:0] OFF_RTAMP = 8'h0a;
   localparam logic [7:0] OFF_UNLK = 8'h0d;
   localparam logic [7:0] OFF_DISTH = 8'h13;
   // ==========================================
   // Field positions and reset values
   localparam int CTL_TRIG = 7;
   localparam int CTL_RAMEN = 6;
   localparam int CTL_CLKEN = 5;
   localparam int CSTAT_BUSY = 1;
   localparam int EINT_TMO = 2;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [6:0] DEV_ADDR = 7'h50;
   localparam int PWM_WIN_BITS = 8;
   // ==========================================
   // Drive mode codes
   localparam logic [4:0] MODE_IDLE = 5'h00;
   localparam logic [4:0] MODE_PWM_LO = 5'h01;
   localparam logic [4:0] MODE_PWM_HI = 5'h05;
   localparam logic [4:0] MODE_RT = 5'h06;
   localparam logic [4:0] MODE_PAT_LO = 5'h07;
   localparam logic [4:0] MODE_PAT_HI = 5'h0b;
   localparam logic [4:0] MODE_PAT_REG = 5'h0c;
   localparam logic [4:0] MODE_RAM_LO = 5'h0d;
   localparam logic [4:0] MODE_RAM_HI = 5'h11;
   localparam logic [4:0] MODE_RAM_REG = 5'h12;
   // ==========================================
   // Types
   typedef enum logic [2:0] {
      DRV_IDLE = 3'b000,
      DRV_PWM = 3'b001,
      DRV_RT = 3'b010,
      DRV_PAT = 3'b011,
      DRV_RAM = 3'b100
   } hap_drv_t;
   typedef struct packed {
      logic [3:0] ocp;
      logic overtemp;
      logic clk_run;
      logic res_lock;
      logic conv_busy;
   } hap_sense_t;
   typedef struct packed {
      logic tune_done;
      logic timeout;
      logic uvlo;
      logic conv_end;
   } hap_evt_t;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } hap_acc_t;
endpackage : hap_pkg
`default_nettype wire

/* core/hap_status_ctrl.sv */
`default_nettype none
// Contract
// [RL1] Supply below disable threshold sets status bit 7 and locks driver.
// [RL2] Four switch overcurrents set status bits 6..3 and lock driver.
// [RL3] Overtemperature sets status bit 2 and locks driver.
// [RL4] Status bit 1 shows driver clock running.
// [RL5] Status bit 0 shows resonance tracking locked.
// [RL6] Summary fault bit is 1 while driver is locked by faults.
// [RL7] Converter status bit 1 shows converter busy.
// [RL8] Each first interrupt flag sets when its status bit changes.
// [RL9] Autotune completion sets event flag bit 3.
// [RL10] Vibration timeout sets event flag bit 2 and locks driver.
// [RL11] Supply undervoltage sets event flag bit 1 and locks driver.
// [RL12] Summary fault change sets event flag bit 0.
// [RL13] Converter busy change sets bit 1, conversion end sets bit 0.
// [RL14] Each flag is gated by same-position mask; 1 unmasks.
// [RL15] Writing trigger bit 1 in register-trigger modes starts vibration.
// [RL16] Control bit 6 enables the pattern RAM block.
// [RL17] Host enables driver clock before a mode, idles mode before clearing.
// [RL18] Modes 1..5 take amplitude from PWM duty on pins 0..4.
// [RL19] Mode 6 drives amplitude from the realtime amplitude register.
// [RL20] Pin-triggered pattern modes start on a pulse on their pin.
// [RL21] Host uses trigger bit instead of a pin in mode 01100.
// [RL22] RAM pattern modes start playback on a pulse on their pin.
// [RL23] Summary fault holds until host writes unlock; unlock self-clears.
// [RL24] Interrupt output is high while any unmasked flag is set.
// [RL25] Mode 0 and undefined modes leave the driver idle, outputs off.
module hap_status_ctrl (
   input wire logic clk, // System clock, 40 MHz
   input wire logic rstn, // Async reset, active low
   input wire logic i2c_scl_i, // Serial clock
   input wire logic i2c_sda_i, // Serial data in
   output logic i2c_sda_o, // Serial data out value
   output logic i2c_sda_oe, // Serial data drive enable
   input wire logic [7:0] supply_level, // Driver supply level code
   input wire hap_pkg::hap_sense_t sense, // Live status levels
   input wire hap_pkg::hap_evt_t evt, // One-cycle event pulses
   input wire logic [4:0] mpc_in, // Multipurpose pin levels
   output logic driver_enable, // Driver running
   output hap_pkg::hap_drv_t drive_kind, // Active drive interface
   output logic [7:0] amplitude, // Output amplitude
   output logic pattern_start, // Stored pattern start pulse
   output logic ram_start, // RAM pattern start pulse
   output logic ram_enable, // Pattern RAM enable
   output logic driver_clk_en, // Driver clock enable
   output logic irq // Interrupt request, active high
);
   // ==========================================
   // Helper functions
   function automatic hap_pkg::hap_drv_t mode_kind(input logic [4:0] m);
      if (m >= hap_pkg::MODE_PWM_LO && m <= hap_pkg::MODE_PWM_HI) return hap_pkg::DRV_PWM;
      if (m == hap_pkg::MODE_RT) return hap_pkg::DRV_RT;
      if (m >= hap_pkg::MODE_PAT_LO && m <= hap_pkg::MODE_PAT_REG) return hap_pkg::DRV_PAT;
      if (m >= hap_pkg::MODE_RAM_LO && m <= hap_pkg::MODE_RAM_REG) return hap_pkg::DRV_RAM;
      return hap_pkg::DRV_IDLE; // RL25
   endfunction
   function automatic logic pin_of(input logic [4:0] m, input logic [4:0] base, input logic [4:0] pins);
      logic [4:0] idx;
      idx = m - base;
      return (idx < 5'd5) ? pins[idx[2:0]] : 1'b0;
   endfunction
   // ==========================================
   // Register bus
   hap_pkg::hap_acc_t acc;
   logic [7:0] ptr, rd_data;
   logic sda_o_ff;
   hap_i2c_slave u_i2c (
      .clk(clk),
      .rstn(rstn),
      .scl_i(i2c_scl_i),
      .sda_i(i2c_sda_i),
      .rd_data(rd_data),
      .sda_oe(i2c_sda_oe),
      .ptr(ptr),
      .acc(acc)
   );
   assign i2c_sda_o = sda_o_ff;
   wire wr_fint = acc.wr && acc.addr == hap_pkg::OFF_FINT;
   wire wr_eint = acc.wr && acc.addr == hap_pkg::OFF_EINT;
   wire wr_cint = acc.wr && acc.addr == hap_pkg::OFF_CINT;
   wire wr_ctrl = acc.wr && acc.addr == hap_pkg::OFF_CTRL;
   wire wr_unlk = acc.wr && acc.addr == hap_pkg::OFF_UNLK;
   // ==========================================
   // State
   logic [7:0] fmsk_ff, ctrl_ff, rtamp_ff, disth_ff, stat0_prev_ff, fint_ff;
   logic [3:0] emsk_ff, eint_ff;
   logic [1:0] cmsk_ff, cint_ff;
   logic [5:0] flt_lat_ff;
   logic flt_ff, flt_prev_ff, busy_prev_ff, unlock_ff;
   localparam int PWM_W = hap_pkg::PWM_WIN_BITS;
   logic [4:0] mpc_prev_ff;
   logic [PWM_W-1:0] win_cnt_ff;
   logic [PWM_W:0] hi_cnt_ff;
   logic [7:0] pwm_amp_ff, amp_ff;
   logic drv_en_ff, pat_ff, ram_ff, irq_ff;
   hap_pkg::hap_drv_t kind_ff;
   // ==========================================
   // Fault and status decoding
   wire supply_low = supply_level < disth_ff;
   wire [5:0] cause = {supply_low, sense.ocp, sense.overtemp};
   wire lock_evt = (|cause) | evt.timeout | evt.uvlo;
   wire [7:0] stat0 = {flt_lat_ff, sense.clk_run, sense.res_lock};
   wire [7:0] stat2 = {6'h00, sense.conv_busy, 1'b0};
   wire [7:0] nxt_fint = (fint_ff & ~(wr_fint ? acc.data : 8'h00)) | (stat0 ^ stat0_prev_ff);
   wire [3:0] eint_clr = wr_eint ? acc.data[3:0] : 4'h0;
   wire [3:0] nxt_eint = (eint_ff & ~eint_clr) | {evt.tune_done, evt.timeout, evt.uvlo, flt_ff ^ flt_prev_ff};
   wire [1:0] cint_clr = wr_cint ? acc.data[1:0] : 2'h0;
   wire [1:0] nxt_cint = (cint_ff & ~cint_clr) | {sense.conv_busy ^ busy_prev_ff, evt.conv_end};
   wire [5:0] nxt_flt_lat = (flt_lat_ff & ~{6{unlock_ff}}) | cause;
   wire nxt_flt = (flt_ff & ~unlock_ff) | lock_evt;
   wire pend = |(fint_ff & fmsk_ff) | |(eint_ff & emsk_ff) | |(cint_ff & cmsk_ff);
   // ==========================================
   // Mode decoding
   wire [4:0] mode = ctrl_ff[4:0];
   hap_pkg::hap_drv_t kind;
   assign kind = mode_kind(mode);
   wire run_ok = ctrl_ff[hap_pkg::CTL_CLKEN] & ~flt_ff;
   wire [4:0] rise = mpc_in & ~mpc_prev_ff;
   wire reg_trig = wr_ctrl & acc.data[hap_pkg::CTL_TRIG];
   wire pat_go = (mode == hap_pkg::MODE_PAT_REG) ? reg_trig : pin_of(mode, hap_pkg::MODE_PAT_LO, rise);
   wire ram_go = (mode == hap_pkg::MODE_RAM_REG) ? reg_trig : pin_of(mode, hap_pkg::MODE_RAM_LO, rise);
   wire pwm_pin = pin_of(mode, hap_pkg::MODE_PWM_LO, mpc_in);
   wire [PWM_W:0] nxt_hi = hi_cnt_ff + {{PWM_W{1'b0}}, pwm_pin};
   wire win_end = &win_cnt_ff;
   wire [7:0] nxt_pwm_amp = nxt_hi[PWM_W] ? 8'hff : nxt_hi[7:0];
   wire [7:0] nxt_amp = !run_ok ? 8'h00 :
                        (kind == hap_pkg::DRV_PWM) ? pwm_amp_ff :
                        (kind == hap_pkg::DRV_RT) ? rtamp_ff : 8'h00;
   // ==========================================
   // Read mux
   assign rd_data = (ptr == hap_pkg::OFF_FSTAT) ? stat0 :
                    (ptr == hap_pkg::OFF_SSTAT) ? {7'h00, flt_ff} :
                    (ptr == hap_pkg::OFF_CSTAT) ? stat2 :
                    (ptr == hap_pkg::OFF_FINT) ? fint_ff :
                    (ptr == hap_pkg::OFF_EINT) ? {4'h0, eint_ff} :
                    (ptr == hap_pkg::OFF_CINT) ? {6'h00, cint_ff} :
                    (ptr == hap_pkg::OFF_FMSK) ? fmsk_ff :
                    (ptr == hap_pkg::OFF_EMSK) ? {4'h0, emsk_ff} :
                    (ptr == hap_pkg::OFF_CMSK) ? {6'h00, cmsk_ff} :
                    (ptr == hap_pkg::OFF_CTRL) ? ctrl_ff :
                    (ptr == hap_pkg::OFF_RTAMP) ? rtamp_ff :
                    (ptr == hap_pkg::OFF_UNLK) ? {7'h00, unlock_ff} :
                    (ptr == hap_pkg::OFF_DISTH) ? disth_ff : 8'h00;
   // ==========================================
   // Host registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fmsk_ff <= hap_pkg::RST_REG;
         emsk_ff <= 4'h0;
         cmsk_ff <= 2'h0;
         ctrl_ff <= hap_pkg::RST_REG;
         rtamp_ff <= hap_pkg::RST_REG;
         disth_ff <= hap_pkg::RST_REG;
      end else if (acc.wr) begin
         if (acc.addr == hap_pkg::OFF_FMSK) fmsk_ff <= acc.data;
         if (acc.addr == hap_pkg::OFF_EMSK) emsk_ff <= acc.data[3:0];
         if (acc.addr == hap_pkg::OFF_CMSK) cmsk_ff <= acc.data[1:0];
         if (wr_ctrl) ctrl_ff <= acc.data; // RL17
         if (acc.addr == hap_pkg::OFF_RTAMP) rtamp_ff <= acc.data;
         if (acc.addr == hap_pkg::OFF_DISTH) disth_ff <= acc.data;
      end
   end
   // ==========================================
   // Fault lock and unlock
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flt_lat_ff <= 6'h00;
         flt_ff <= 1'b0;
         flt_prev_ff <= 1'b0;
         unlock_ff <= 1'b0;
      end else begin
         flt_lat_ff <= nxt_flt_lat; // RL1 RL2 RL3
         flt_ff <= nxt_flt; // RL6 RL10 RL11
         flt_prev_ff <= flt_ff;
         unlock_ff <= wr_unlk & acc.data[0] & ~unlock_ff; // RL23
      end
   end
   // ==========================================
   // Interrupt flags
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stat0_prev_ff <= 8'h00;
         busy_prev_ff <= 1'b0;
         fint_ff <= 8'h00;
         eint_ff <= 4'h0;
         cint_ff <= 2'h0;
         irq_ff <= 1'b0;
      end else begin
         stat0_prev_ff <= stat0; // RL4 RL5
         busy_prev_ff <= sense.conv_busy; // RL7
         fint_ff <= nxt_fint; // RL8
         eint_ff <= nxt_eint; // RL9 RL12
         cint_ff <= nxt_cint; // RL13
         irq_ff <= pend; // RL14 RL24
      end
   end
   // ==========================================
   // Drive control
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mpc_prev_ff <= 5'h00;
         win_cnt_ff <= '0;
         hi_cnt_ff <= '0;
         pwm_amp_ff <= 8'h00;
         amp_ff <= 8'h00;
         drv_en_ff <= 1'b0;
         pat_ff <= 1'b0;
         ram_ff <= 1'b0;
         sda_o_ff <= 1'b0;
         kind_ff <= hap_pkg::DRV_IDLE;
      end else begin
         mpc_prev_ff <= mpc_in;
         win_cnt_ff <= win_cnt_ff + {{(PWM_W-1){1'b0}}, 1'b1};
         hi_cnt_ff <= win_end ? '0 : nxt_hi;
         if (win_end) pwm_amp_ff <= nxt_pwm_amp; // RL18
         amp_ff <= nxt_amp; // RL19 RL25
         kind_ff <= kind;
         drv_en_ff <= run_ok && kind != hap_pkg::DRV_IDLE; // RL25
         pat_ff <= run_ok && kind == hap_pkg::DRV_PAT && pat_go; // RL15 RL20 RL21
         ram_ff <= run_ok && kind == hap_pkg::DRV_RAM && ram_go && ctrl_ff[hap_pkg::CTL_RAMEN]; // RL15 RL22
         sda_o_ff <= 1'b0;
      end
   end
   assign driver_enable = drv_en_ff;
   assign drive_kind = kind_ff;
   assign amplitude = amp_ff;
   assign pattern_start = pat_ff;
   assign ram_start = ram_ff;
   assign ram_enable = ctrl_ff[hap_pkg::CTL_RAMEN]; // RL16
   assign driver_clk_en = ctrl_ff[hap_pkg::CTL_CLKEN];
   assign irq = irq_ff;
   // ==========================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   unlock_self_a: assert property (unlock_ff |=> !unlock_ff) else $error("unlock did not self clear"); // RL23
   fault_hold_a: assert property (flt_ff && !unlock_ff |=> flt_ff) else $error("fault dropped w/o unlock"); // RL23
   supply_lock_a: assert property (supply_low |=> flt_lat_ff[5] && flt_ff ##1 !drv_en_ff)
      else $error("supply fault not locked"); // RL1
   ocp_lock_a: assert property (|sense.ocp |=> (flt_lat_ff[4:1] & $past(sense.ocp)) == $past(sense.ocp))
      else $error("overcurrent not latched"); // RL2
   change_flag_a: assert property ((stat0 != stat0_prev_ff) |=> (fint_ff & $past(stat0 ^ stat0_prev_ff)) != 8'h00)
      else $error("status change flag lost"); // RL8
   timeout_flag_a: assert property (evt.timeout |=> eint_ff[hap_pkg::EINT_TMO] && flt_ff)
      else $error("timeout flag missing"); // RL10
   irq_gate_a: assert property ($rose(pend) |=> irq_ff) else $error("irq not raised"); // RL24
   irq_mask_a: assert property (!pend |=> !irq_ff) else $error("irq without unmasked flag"); // RL14
   reg_trig_a: assert property (reg_trig && run_ok && mode == hap_pkg::MODE_PAT_REG |=> pat_ff)
      else $error("register trigger missed"); // RL15
   idle_off_a: assert property (kind == hap_pkg::DRV_IDLE |=> !drv_en_ff && amp_ff == 8'h00)
      else $error("idle mode drives"); // RL25
   rt_amp_a: assert property (run_ok && kind == hap_pkg::DRV_RT |=> amp_ff == $past(rtamp_ff))
      else $error("realtime amplitude wrong"); // RL19
endmodule // hap_status_ctrl
`default_nettype wire

/* sim/hap_host_model.sv */
`default_nettype none
module hap_host_model (
   input wire logic clk, // System clock
   input wire logic sda_oe, // Device pulls data low
   output logic scl, // Serial clock level
   output logic sda // Data wire level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sda_drv = 1'b1;
   initial scl = 1'b1;
   // Pull-up wire: low when either party drives
   assign sda = sda_drv & ~sda_oe;
   // ==========================================
   // Bus cycles
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic edge_seq(input logic d0, input logic d1);
      tick(2);
      sda_drv = d0;
      tick(3);
      scl = 1'b1;
      tick(4);
      sda_drv = d1;
   endtask
   task automatic bit_io(input logic b, output logic r);
      edge_seq(b, b);
      r = sda;
      scl = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q, output logic nak);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ack, nak);
   endtask
   task automatic start;
      edge_seq(1'b1, 1'b0);
      tick(4);
      scl = 1'b0;
   endtask
   task automatic stop;
      edge_seq(1'b0, 1'b1);
      tick(4);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic bad);
      logic [7:0] q;
      logic n0, n1, n2;
      start();
      xfer({hap_pkg::DEV_ADDR, 1'b0}, 1'b1, q, n0);
      xfer(a, 1'b1, q, n1);
      xfer(d, 1'b1, q, n2);
      stop();
      bad = n0 | n1 | n2;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic bad);
      logic [7:0] q;
      logic n0, n1, n2, n3;
      start();
      xfer({hap_pkg::DEV_ADDR, 1'b0}, 1'b1, q, n0);
      xfer(a, 1'b1, q, n1);
      start();
      xfer({hap_pkg::DEV_ADDR, 1'b1}, 1'b1, q, n2);
      xfer(8'hff, 1'b1, d, n3);
      stop();
      bad = n0 | n1 | n2;
   endtask
endmodule // hap_host_model
`default_nettype wire

/* sim/hap_status_ctrl_bench.sv */
`default_nettype none
module hap_status_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic scl, sda, sda_oe, driver_enable, pattern_start, ram_start, ram_enable, driver_clk_en, irq;
   logic [7:0] supply_level = 8'hff;
   logic [7:0] amplitude;
   logic [4:0] mpc_in = 5'h00;
   hap_pkg::hap_sense_t sense = '0;
   hap_pkg::hap_evt_t evt = '0;
   hap_pkg::hap_drv_t drive_kind;
   int errors = 0;
   int check_count = 0;
   int pat_cnt = 0;
   int ram_cnt = 0;
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      pat_cnt <= pat_cnt + int'(pattern_start === 1'b1);
      ram_cnt <= ram_cnt + int'(ram_start === 1'b1);
   end
   hap_host_model hap_host_model_inst (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   hap_status_ctrl hap_status_ctrl_inst (.clk(clk), .rstn(rstn), .i2c_scl_i(scl), .i2c_sda_i(sda),
      .i2c_sda_o(), .i2c_sda_oe(sda_oe), .supply_level(supply_level), .sense(sense), .evt(evt),
      .mpc_in(mpc_in), .driver_enable(driver_enable), .drive_kind(drive_kind), .amplitude(amplitude),
      .pattern_start(pattern_start), .ram_start(ram_start), .ram_enable(ram_enable),
      .driver_clk_en(driver_clk_en), .irq(irq));
   // ==========================================
   // Helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      logic bad;
      hap_host_model_inst.rd(a, q, bad);
      chk({7'h0, bad}, 8'h00, "read ack");
      chk(q, exp, $sformatf("reg %h", a));
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      logic bad;
      hap_host_model_inst.wr(a, d, bad);
      chk({7'h0, bad}, 8'h00, "write ack");
   endtask
   task automatic outs(input logic en, input logic [2:0] kind, input logic i);
      cyc(3);
      chk({7'h0, en}, {7'h0, driver_enable}, "driver enable");
      chk({5'h0, kind}, {5'h0, drive_kind}, "drive kind");
      chk({7'h0, i}, {7'h0, irq}, "irq");
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset;
      for (int a = 0; a < 10; a++) begin
         rchk(8'(a), hap_pkg::RST_REG);
      end
      rchk(8'h30, 8'h00);
      outs(1'b0, hap_pkg::DRV_IDLE, 1'b0);
      $display("test reset done");
   endtask
   task automatic t_status;
      sense.clk_run = 1'b1;
      sense.res_lock = 1'b1;
      sense.conv_busy = 1'b1;
      rchk(hap_pkg::OFF_FSTAT, 8'h03);
      rchk(hap_pkg::OFF_CSTAT, 8'h02);
      rchk(hap_pkg::OFF_FINT, 8'h03);
      rchk(hap_pkg::OFF_CINT, 8'h02);
      outs(1'b0, hap_pkg::DRV_IDLE, 1'b0);
      wreg(hap_pkg::OFF_FMSK, 8'h01);
      outs(1'b0, hap_pkg::DRV_IDLE, 1'b1);
      wreg(hap_pkg::OFF_FINT, 8'hff);
      wreg(hap_pkg::OFF_CINT, 8'hff);
      outs(1'b0, hap_pkg::DRV_IDLE, 1'b0);
      wreg(hap_pkg::OFF_FMSK, 8'h00);
      $display("test status done");
   endtask
   task automatic t_fault;
      wreg(hap_pkg::OFF_DISTH, 8'h80);
      sense.ocp = 4'b1001;
      sense.overtemp = 1'b1;
      supply_level = 8'h40;
      cyc(4);
      sense.ocp = 4'b0000;
      sense.overtemp = 1'b0;
      supply_level = 8'hff;
      rchk(hap_pkg::OFF_FSTAT, 8'hcf);
      rchk(hap_pkg::OFF_SSTAT, 8'h01);
      rchk(hap_pkg::OFF_FINT, 8'hcc);
      rchk(hap_pkg::OFF_EINT, 8'h01);
      wreg(hap_pkg::OFF_UNLK, 8'h01);
      rchk(hap_pkg::OFF_UNLK, 8'h00);
      rchk(hap_pkg::OFF_SSTAT, 8'h00);
      rchk(hap_pkg::OFF_FSTAT, 8'h03);
      wreg(hap_pkg::OFF_FINT, 8'hff);
      wreg(hap_pkg::OFF_EINT, 8'hff);
      $display("test fault done");
   endtask
   task automatic t_modes;
      wreg(hap_pkg::OFF_RTAMP, 8'h5a);
      wreg(hap_pkg::OFF_CTRL, 8'h20);
      wreg(hap_pkg::OFF_CTRL, 8'h26);
      outs(1'b1, hap_pkg::DRV_RT, 1'b0);
      chk(amplitude, 8'h5a, "rt amplitude");
      chk({7'h0, driver_clk_en}, 8'h01, "clock enable");
      for (int i = 0; i < 5; i++) begin
         mpc_in = 5'(1 << i);
         wreg(hap_pkg::OFF_CTRL, 8'h21 + 8'(i));
         cyc(600);
         chk(amplitude, 8'hff, "pwm amplitude");
         mpc_in = ~5'(1 << i);
         cyc(600);
         chk(amplitude, 8'h00, "pwm other pins");
      end
      mpc_in = 5'h00;
      $display("test modes done");
   endtask
   task automatic t_trig;
      int p;
      int r;
      for (int i = 0; i < 5; i++) begin
         wreg(hap_pkg::OFF_CTRL, 8'h27 + 8'(i));
         wreg(hap_pkg::OFF_CTRL, 8'h6d + 8'(i));
      end
      for (int i = 0; i < 10; i++) begin
         p = pat_cnt;
         r = ram_cnt;
         wreg(hap_pkg::OFF_CTRL, (i < 5) ? 8'h27 + 8'(i) : 8'h68 + 8'(i));
         mpc_in[i % 5] = 1'b1;
         cyc(2);
         mpc_in = 5'h00;
         cyc(2);
         chk(8'(pat_cnt - p), (i < 5) ? 8'h01 : 8'h00, "pin pattern start");
         chk(8'(ram_cnt - r), (i < 5) ? 8'h00 : 8'h01, "pin ram start");
      end
      chk({7'h0, ram_enable}, 8'h01, "ram enable");
      p = pat_cnt;
      wreg(hap_pkg::OFF_CTRL, 8'h2c);
      wreg(hap_pkg::OFF_CTRL, 8'hac);
      cyc(3);
      chk(8'(pat_cnt - p), 8'h01, "reg pattern start");
      r = ram_cnt;
      wreg(hap_pkg::OFF_CTRL, 8'h72);
      wreg(hap_pkg::OFF_CTRL, 8'hf2);
      cyc(3);
      chk(8'(ram_cnt - r), 8'h01, "reg ram start");
      wreg(hap_pkg::OFF_CTRL, 8'h20);
      chk({7'h0, ram_enable}, 8'h00, "ram disable");
      $display("test triggers done");
   endtask
   task automatic t_events;
      wreg(hap_pkg::OFF_CTRL, 8'h26);
      wreg(hap_pkg::OFF_EMSK, 8'h04);
      evt = 4'hf;
      cyc(1);
      evt = 4'h0;
      outs(1'b0, hap_pkg::DRV_RT, 1'b1);
      rchk(hap_pkg::OFF_EINT, 8'h0f);
      rchk(hap_pkg::OFF_CINT, 8'h01);
      rchk(hap_pkg::OFF_SSTAT, 8'h01);
      wreg(hap_pkg::OFF_UNLK, 8'h01);
      wreg(hap_pkg::OFF_EINT, 8'hff);
      wreg(hap_pkg::OFF_CINT, 8'hff);
      outs(1'b1, hap_pkg::DRV_RT, 1'b0);
      wreg(hap_pkg::OFF_CTRL, 8'h20);
      outs(1'b0, hap_pkg::DRV_IDLE, 1'b0);
      wreg(hap_pkg::OFF_CTRL, 8'h3f);
      outs(1'b0, hap_pkg::DRV_IDLE, 1'b0);
      chk(amplitude, 8'h00, "idle amplitude");
      wreg(hap_pkg::OFF_CTRL, 8'h00);
      chk({7'h0, driver_clk_en}, 8'h00, "clock disable");
      $display("test events done");
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      cyc(3);
      rstn = 1'b1;
      cyc(2);
      t_reset();
      t_status();
      t_fault();
      t_modes();
      t_trig();
      t_events();
      end_sim();
   end
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim();
   end
endmodule // hap_status_ctrl_bench
`default_nettype wire
